// *** tb/cwce_core_sva.sv ***
// Checker for the clear-watchdog and complement block, watching APB and busy.
// Assumes the core's single pclk domain and its active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module cwce_core_sva (
  input wire logic        pclk,    // Core clock.
  input wire logic        presetn, // Reset, active low.
  input wire logic        psel,    // APB select.
  input wire logic        penable, // APB enable.
  input wire logic        pwrite,  // APB direction.
  input wire logic [7:0]  paddr,   // APB address.
  input wire logic [31:0] pwdata,  // APB write data.
  input wire logic [31:0] prdata,  // APB read data.
  input wire logic        pready,  // APB ready.
  input wire logic        pslverr, // APB error.
  input wire logic        busy     // Instruction running.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An access phase that has not yet been answered.
  wire take  = psel && penable && !pready;
  wire memrd = !pwrite && (paddr == 8'h18);
  a_ready_take: assert property (take && !memrd |=> pready)
    else $error("ready missing one cycle after access");
  a_ready_memrd: assert property ($rose(take) && memrd |=> !pready ##1 pready)
    else $error("memory read answer not two cycles after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (take && paddr > 8'h18 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_busy_start: assert property (take && pwrite && paddr == 8'h00 && !busy |=> busy)
    else $error("instruction write did not start execution");
  a_busy_span: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
    else $error("execution not four quarter phases");
  a_busy_refuse: assert property (take && pwrite && busy |=> pslverr)
    else $error("write while busy not refused");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule : cwce_core_sva
bind cwce_core cwce_core_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire

// *** tb/cwce_core_tb.sv ***
// Self-checking bench for the clear-watchdog and complement block.
// Assumes the block alone, driven over APB; the checker is attached by bind.
`timescale 1ns/1ps
`default_nettype none
module cwce_core_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  int          failures, num_checks;
  cwce_core #(.WDOG_WIDTH(16), .POST_WIDTH(8), .WDOG_PRESCALE(16'h0100)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  // Free-running 50 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rv = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Let one edge pass idle so the next setup never reassigns in this step.
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Issues one instruction word and waits for execution to finish.
  task automatic run(input logic [15:0] op);
    int n;
    n = 0;
    wr(cwce_pkg::INSTR_OFFSET, {16'h0, op});
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 20);
    if (n >= 20) failures++;
  endtask : run
  task automatic t_complement_byte_instr_acc;
    wr(cwce_pkg::CTRL_OFFSET, 32'h30);
    wr(cwce_pkg::ADDR_OFFSET, 32'h020);
    wr(cwce_pkg::MEM_OFFSET, 32'h13);
    run(16'h1c20);
    rd(cwce_pkg::ACCUM_OFFSET);
    chk("accum", rv, 32'hec);
    rd(cwce_pkg::MEM_OFFSET);
    chk("byte", rv, 32'h13);
    rd(cwce_pkg::STATUS_OFFSET);
    chk("status", rv, 32'h0e);
    run(16'h1820);
    rd(cwce_pkg::ACCUM_OFFSET);
    chk("accum", rv, 32'hec);
  endtask : t_complement_byte_instr_acc
  task automatic t_complement_byte_instr_bank;
    wr(cwce_pkg::ADDR_OFFSET, 32'h345);
    wr(cwce_pkg::MEM_OFFSET, 32'hff);
    run(16'h1f45);
    rd(cwce_pkg::MEM_OFFSET);
    chk("byte", rv, 32'h00);
    rd(cwce_pkg::STATUS_OFFSET);
    chk("status", rv, 32'h0d);
    rd(cwce_pkg::ACCUM_OFFSET);
    chk("accum", rv, 32'hec);
  endtask : t_complement_byte_instr_bank
  task automatic t_indexed;
    wr(cwce_pkg::CTRL_OFFSET, 32'h8001);
    wr(cwce_pkg::ADDR_OFFSET, 32'h090);
    wr(cwce_pkg::MEM_OFFSET, 32'h5a);
    wr(cwce_pkg::ADDR_OFFSET, 32'h010);
    wr(cwce_pkg::MEM_OFFSET, 32'h77);
    run(16'h1e10);
    rd(cwce_pkg::MEM_OFFSET);
    chk("access", rv, 32'h77);
    wr(cwce_pkg::ADDR_OFFSET, 32'h090);
    rd(cwce_pkg::MEM_OFFSET);
    chk("indexed", rv, 32'ha5);
  endtask : t_indexed
  task automatic t_clear_watchdog_instr;
    wr(cwce_pkg::STATUS_OFFSET, 32'h3);
    run(16'h0005);
    rd(cwce_pkg::STATUS_OFFSET);
    chk("status", rv, 32'h3);
    repeat (600) @(posedge pclk);
    rd(cwce_pkg::WDOG_OFFSET);
    chk("wdog_ran", {31'h0, rv !== 32'h0}, 32'h1);
    run(16'h0004);
    rd(cwce_pkg::STATUS_OFFSET);
    chk("status", rv, 32'hf);
    rd(cwce_pkg::WDOG_OFFSET);
    chk("wdog", rv, 32'h0);
  endtask : t_clear_watchdog_instr
  // A write during execution and an unmapped read are both refused.
  task automatic t_refuse;
    wr(cwce_pkg::INSTR_OFFSET, 32'h1c10);
    wr(cwce_pkg::CTRL_OFFSET, 32'h0);
    chk("busy_err", {31'h0, re}, 32'h1);
    repeat (6) @(posedge pclk);
    rd(cwce_pkg::CTRL_OFFSET);
    chk("ctrl", rv, 32'h8001);
    rd(cwce_pkg::ACCUM_OFFSET);
    chk("accum_idx", rv, 32'h5a);
    rd(8'h40);
    chk("unmapped", {31'h0, re}, 32'h1);
    chk("unmapped_data", rv, 32'h0);
  endtask : t_refuse
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Hang guard, well beyond the expected run of about 780 cycles.
  initial begin
    #100us;
    failures++;
    conclude();
  end
  // Main sequence.
  initial begin
    failures = 0; num_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(cwce_pkg::STATUS_OFFSET);
    chk("status_rst", rv, 32'h0c);
    t_complement_byte_instr_acc();
    t_complement_byte_instr_bank();
    t_indexed();
    t_refuse();
    t_clear_watchdog_instr();
    conclude();
  end
endmodule : cwce_core_tb
`default_nettype wire

// *** verilog/cwce_core.sv ***
// Execution block for the clear-watchdog and complement-byte instructions.
// Assumes APB at 50 MHz; software issues an instruction by writing its word.
`timescale 1ns/1ps
`default_nettype none
module cwce_core #(
  parameter int          WDOG_WIDTH   = 16,  // Watchdog counter width.
  parameter int          POST_WIDTH   = 8,   // Postscaler width.
  parameter logic [15:0] WDOG_PRESCALE = 16'h0100 // Pclk cycles per watchdog tick.
) (
  input  wire logic        pclk,     // Core clock, 50 MHz.
  input  wire logic        presetn,  // Asynchronous reset, active low.
  input  wire logic        psel,     // APB select.
  input  wire logic        penable,  // APB enable.
  input  wire logic        pwrite,   // APB direction.
  input  wire logic [7:0]  paddr,    // APB byte address.
  input  wire logic [31:0] pwdata,   // APB write data.
  output logic      [31:0] prdata,   // APB read data.
  output logic             pready,   // APB ready.
  output logic             pslverr,  // APB error on unmapped address or on a write during execution.
  output logic             busy      // High while an instruction executes.
);
  localparam int AW = 12;

  cwce_mem_if #(.AW(AW)) mem ();

  cwce_data_mem #(.AW(AW)) u_mem (
    .pclk (pclk),
    .port (mem.mem)
  );

  cwce_pkg::cwce_phase_t phase_reg, phase_next;
  logic [15:0]           instr_reg;
  logic [7:0]            accum_reg;
  logic                  extended_reg;
  logic [3:0]            bank_select_reg;
  logic [7:0]            index_base_reg;
  logic                  zero_flag_reg;
  logic                  negative_flag_reg;
  logic                  sleep_entered_flag_reg;
  logic                  watchdog_expired_flag_reg;
  logic [WDOG_WIDTH-1:0] watchdog_counter_reg;
  logic [POST_WIDTH-1:0] postscaler_reg;
  logic [15:0]           prescale_reg;
  logic [7:0]            result_reg;
  logic [AW-1:0]         addr_reg;
  logic                  sw_we_reg;
  logic [AW-1:0]         sw_addr_reg;
  logic [7:0]            sw_wdata_reg;
  logic                  wait_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;

  // APB decode; an access completes one cycle after its first enable cycle, memory reads one cycle later.
  wire access     = psel & penable & ~pready_reg;
  wire wr_access  = access & pwrite;
  wire hit_instr  = paddr == cwce_pkg::INSTR_OFFSET;
  wire hit_ctrl   = paddr == cwce_pkg::CTRL_OFFSET;
  wire hit_accum  = paddr == cwce_pkg::ACCUM_OFFSET;
  wire hit_status = paddr == cwce_pkg::STATUS_OFFSET;
  wire hit_wdog   = paddr == cwce_pkg::WDOG_OFFSET;
  wire hit_addr   = paddr == cwce_pkg::ADDR_OFFSET;
  wire hit_mem    = paddr == cwce_pkg::MEM_OFFSET;
  wire mapped     = hit_instr | hit_ctrl | hit_accum | hit_status | hit_wdog |
                    hit_addr | hit_mem;
  wire executing  = phase_reg != cwce_pkg::CWCE_IDLE;
  wire issue      = wr_access & hit_instr & ~executing;

  // Instruction decode.
  wire is_clear_watchdog = instr_reg == cwce_pkg::CLEAR_WATCHDOG_OPCODE;
  wire is_complement     = instr_reg[15:cwce_pkg::COMPLEMENT_PREFIX_LSB] ==
                           cwce_pkg::COMPLEMENT_PREFIX;
  wire       dest_file   = instr_reg[cwce_pkg::DEST_BIT];
  wire       bank_bit    = instr_reg[cwce_pkg::BANK_BIT];
  wire [7:0] file_addr   = instr_reg[7:0];

  // Effective address: banked, indexed, or access bank split at 0x60.
  wire       use_indexed = extended_reg & ~bank_bit &
                           (file_addr <= cwce_pkg::INDEXED_LIMIT);
  wire [7:0] index_sum   = 8'(index_base_reg + file_addr);                      // Wraps in 8 bits.
  wire [3:0] access_bank = (file_addr <= cwce_pkg::INDEXED_LIMIT) ? 4'h0 : 4'hf;
  wire [AW-1:0] eff_addr = bank_bit    ? {bank_select_reg, file_addr} :
                           use_indexed ? {4'h0, index_sum} :
                                         {access_bank, file_addr};

  // Complement result and its flags.
  wire [7:0] complement = ~mem.rdata;
  wire       result_neg = result_reg[7];
  wire       result_zero = result_reg == 8'h00;

  // Memory port: the core writes in Q4, software otherwise.
  wire core_write = (phase_reg == cwce_pkg::CWCE_Q4) & is_complement & dest_file;
  assign mem.we    = core_write | sw_we_reg;
  assign mem.addr  = executing ? addr_reg : sw_addr_reg;
  assign mem.wdata = core_write ? result_reg : sw_wdata_reg;

  // Watchdog tick comes from a prescaler pulse.
  wire wdog_tick = prescale_reg == WDOG_PRESCALE - 16'h0001;
  wire post_wrap = postscaler_reg == {POST_WIDTH{1'b1}};
  wire clear_wdog = (phase_reg == cwce_pkg::CWCE_Q3) & is_clear_watchdog;

  // Quarter phase sequence, started by an instruction write.
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      cwce_pkg::CWCE_IDLE: begin
        if (issue) begin
          phase_next = cwce_pkg::CWCE_Q1;
        end
      end
      cwce_pkg::CWCE_Q1: phase_next = cwce_pkg::CWCE_Q2;
      cwce_pkg::CWCE_Q2: phase_next = cwce_pkg::CWCE_Q3;
      cwce_pkg::CWCE_Q3: phase_next = cwce_pkg::CWCE_Q4;
      cwce_pkg::CWCE_Q4: phase_next = cwce_pkg::CWCE_IDLE;
      default:           phase_next = cwce_pkg::CWCE_IDLE;
    endcase
  end

  // Phase register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= cwce_pkg::CWCE_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Instruction capture on issue, address latch in Q1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= 16'h0000;
      addr_reg  <= '0;
    end else begin
      if (issue) begin
        instr_reg <= pwdata[15:0];
      end
      if (phase_reg == cwce_pkg::CWCE_Q1) begin
        addr_reg <= eff_addr;
      end
    end
  end

  // Q3 processes the byte read in Q2.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 8'h00;
    end else if (phase_reg == cwce_pkg::CWCE_Q3 && is_complement) begin
      result_reg <= complement;
    end
  end

  // Accumulator: Q4 write for d zero, or software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_reg <= cwce_pkg::ACCUM_RESET;
    end else if (phase_reg == cwce_pkg::CWCE_Q4 && is_complement && !dest_file) begin
      accum_reg <= result_reg;
    end else if (wr_access && hit_accum && !executing) begin
      accum_reg <= pwdata[7:0];
    end
  end

  // Status flags; instruction effects win over software writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_flag_reg             <= 1'b0;
      negative_flag_reg         <= 1'b0;
      sleep_entered_flag_reg    <= 1'b1;
      watchdog_expired_flag_reg <= 1'b1;
    end else if (phase_reg == cwce_pkg::CWCE_Q4 && is_complement) begin
      negative_flag_reg <= result_neg;
      zero_flag_reg     <= result_zero;
    end else if (clear_wdog) begin
      sleep_entered_flag_reg    <= 1'b1;
      watchdog_expired_flag_reg <= 1'b1;
    end else if (wr_access && hit_status && !executing) begin
      zero_flag_reg             <= pwdata[cwce_pkg::STAT_ZERO_BIT];
      negative_flag_reg         <= pwdata[cwce_pkg::STAT_NEG_BIT];
      sleep_entered_flag_reg    <= pwdata[cwce_pkg::STAT_SLEEP_BIT];
      watchdog_expired_flag_reg <= pwdata[cwce_pkg::STAT_EXPIRED_BIT];
    end
  end

  // Watchdog counter and postscaler, cleared by the instruction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg         <= 16'h0000;
      postscaler_reg       <= '0;
      watchdog_counter_reg <= '0;
    end else if (clear_wdog) begin
      prescale_reg         <= 16'h0000;
      postscaler_reg       <= '0;
      watchdog_counter_reg <= '0;
    end else begin
      prescale_reg <= wdog_tick ? 16'h0000 : prescale_reg + 16'h0001;
      if (wdog_tick) begin
        postscaler_reg <= postscaler_reg + POST_WIDTH'(1);
        if (post_wrap) begin
          watchdog_counter_reg <= watchdog_counter_reg + WDOG_WIDTH'(1);
        end
      end
    end
  end

  // Control register and software memory port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_reg    <= 1'b0;
      bank_select_reg <= cwce_pkg::BANK_RESET;
      index_base_reg  <= 8'h00;
      sw_addr_reg     <= '0;
      sw_wdata_reg    <= 8'h00;
      sw_we_reg       <= 1'b0;
    end else begin
      sw_we_reg <= wr_access & hit_mem & ~executing;
      if (wr_access && hit_ctrl && !executing) begin
        extended_reg    <= pwdata[cwce_pkg::CTRL_EXTENDED_BIT];
        bank_select_reg <= pwdata[cwce_pkg::CTRL_BANK_LSB +: 4];
        index_base_reg  <= pwdata[15:8];
      end
      if (wr_access && hit_addr && !executing) begin
        sw_addr_reg <= pwdata[AW-1:0];
      end
      if (wr_access && hit_mem && !executing) begin
        sw_wdata_reg <= pwdata[7:0];
      end
    end
  end

  // Read data selection.
  wire [31:0] status_word = {27'h0, executing, watchdog_expired_flag_reg,
                             sleep_entered_flag_reg, negative_flag_reg, zero_flag_reg};
  wire [31:0] rd_mux =
      hit_instr  ? {16'h0, instr_reg} :
      hit_ctrl   ? {16'h0, index_base_reg, bank_select_reg, 3'h0, extended_reg} :
      hit_accum  ? {24'h0, accum_reg} :
      hit_status ? status_word :
      hit_wdog   ? {{(32-WDOG_WIDTH-POST_WIDTH){1'b0}}, watchdog_counter_reg,
                    postscaler_reg} :
      hit_addr   ? {{(32-AW){1'b0}}, sw_addr_reg} :
      hit_mem    ? {24'h0, mem.rdata} : 32'h0;

  // APB answer: wait one cycle for registered memory, refuse writes during execution.
  wire hold = access & hit_mem & ~pwrite & ~wait_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      wait_reg    <= 1'b0;
    end else begin
      wait_reg    <= hold;
      pready_reg  <= access & ~hold;
      pslverr_reg <= access & ~hold & (~mapped | (pwrite & executing));
      prdata_reg  <= (access & ~pwrite & ~hold) ? rd_mux : 32'h0;  // Zero outside answer.
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= phase_next != cwce_pkg::CWCE_IDLE;
    end
  end
endmodule : cwce_core
`default_nettype wire

// *** verilog/cwce_data_mem.sv ***
// Small data memory with a registered read port.
// Assumes synchronous write and read on pclk, no reset of the contents.
`timescale 1ns/1ps
`default_nettype none
module cwce_data_mem #(
  parameter int AW = 12
) (
  input  wire logic pclk,   // Core clock.
  cwce_mem_if.mem   port    // Memory port.
);
  logic [7:0] store [0:(1<<AW)-1];
  logic [7:0] rdata_reg;

  // Writes land at the clock edge; read data come out of a register.
  always_ff @(posedge pclk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rdata_reg <= store[port.addr];
  end

  assign port.rdata = rdata_reg;
endmodule : cwce_data_mem
`default_nettype wire

// *** verilog/cwce_mem_if.sv ***
// Interface carrying the data-memory port between the core and its memory.
// Assumes a single clock; one write port and one registered read port.
`timescale 1ns/1ps
`default_nettype none
interface cwce_mem_if #(parameter int AW = 12);
  logic [AW-1:0] addr;
  logic          we;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface : cwce_mem_if
`default_nettype wire

// *** verilog/cwce_pkg.sv ***
// Package for the clear-watchdog and complement execution block.
// Assumes a 50 MHz pclk and an APB register bus with 32-bit data.
`default_nettype none
package cwce_pkg;
  // Opcodes.
  localparam logic [15:0] CLEAR_WATCHDOG_OPCODE = 16'h0004;
  localparam logic [5:0]  COMPLEMENT_PREFIX     = 6'h07;
  localparam int          COMPLEMENT_PREFIX_LSB = 10;
  localparam int          DEST_BIT              = 9;
  localparam int          BANK_BIT              = 8;
  // Indexed literal offset upper limit.
  localparam logic [7:0]  INDEXED_LIMIT         = 8'h5f;
  // Register byte offsets.
  localparam logic [7:0]  INSTR_OFFSET          = 8'h00;
  localparam logic [7:0]  CTRL_OFFSET           = 8'h04;
  localparam logic [7:0]  ACCUM_OFFSET          = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET         = 8'h0c;
  localparam logic [7:0]  WDOG_OFFSET           = 8'h10;
  localparam logic [7:0]  ADDR_OFFSET           = 8'h14;
  localparam logic [7:0]  MEM_OFFSET            = 8'h18;
  // Control register fields.
  localparam int          CTRL_EXTENDED_BIT     = 0;
  localparam int          CTRL_BANK_LSB         = 4;
  // Status register fields.
  localparam int          STAT_ZERO_BIT         = 0;
  localparam int          STAT_NEG_BIT          = 1;
  localparam int          STAT_SLEEP_BIT        = 2;
  localparam int          STAT_EXPIRED_BIT      = 3;
  localparam int          STAT_BUSY_BIT         = 4;
  // Reset values.
  localparam logic [7:0]  ACCUM_RESET           = 8'h00;
  localparam logic [3:0]  BANK_RESET            = 4'h0;
  // Quarter phases of one instruction cycle.
  typedef enum logic [2:0] {
    CWCE_IDLE = 3'b000,
    CWCE_Q1   = 3'b001,
    CWCE_Q2   = 3'b010,
    CWCE_Q3   = 3'b011,
    CWCE_Q4   = 3'b100
  } cwce_phase_t;
endpackage : cwce_pkg
`default_nettype wire
